// >>> bench/cfm_top_properties.sv
// checker for the custom profile register bank and monitor
// assumes it is bound to cfm_top, one clock, rst synchronous active high
`timescale 1ns/10ps
`default_nettype none
module cfm_top_properties (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [6:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rvalid,
  input wire logic        freq_fail,
  input wire logic        window_done,
  input wire logic [15:0] last_count,
  input wire logic [7:0]  profile_a_low_limit_lsbyte,
  input wire logic [7:0]  profile_a_low_limit_msbyte,
  input wire logic [7:0]  profile_a_high_limit_lsbyte,
  input wire logic [7:0]  profile_a_high_limit_msbyte,
  input wire logic [7:0]  profile_a_window_cycle_count,
  input wire logic        profile_a_prescale_enable,
  input wire logic [7:0]  profile_b_multiplier_low,
  input wire logic [5:0]  profile_b_multiplier_high
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // assembled 16-bit limits
  wire [15:0] lo_lim = {profile_a_low_limit_msbyte, profile_a_low_limit_lsbyte};
  wire [15:0] hi_lim = {profile_a_high_limit_msbyte, profile_a_high_limit_lsbyte};
  // writes reach the outputs one cycle later
  a_low_lsb_write: assert property (reg_wr && reg_addr == 7'h6b |=>
    profile_a_low_limit_lsbyte == $past(reg_wdata)) else $error("low limit byte not written");
  a_low_msb_write: assert property (reg_wr && reg_addr == 7'h6c |=>
    profile_a_low_limit_msbyte == $past(reg_wdata)) else $error("low limit msb wrong");
  a_high_lsb_write: assert property (reg_wr && reg_addr == 7'h6d |=>
    profile_a_high_limit_lsbyte == $past(reg_wdata)) else $error("high limit lsb wrong");
  a_high_msb_write: assert property (reg_wr && reg_addr == 7'h6e |=>
    profile_a_high_limit_msbyte == $past(reg_wdata)) else $error("high limit byte not written");
  a_cycles_write: assert property (reg_wr && reg_addr == 7'h6f |=>
    profile_a_window_cycle_count == $past(reg_wdata)) else $error("cycle count not written");
  a_cycles_hold: assert property (!(reg_wr && reg_addr == 7'h6f) |=>
    $stable(profile_a_window_cycle_count)) else $error("cycle count changed unasked");
  a_prescale_bit: assert property (reg_wr && reg_addr == 7'h70 |=>
    profile_a_prescale_enable == $past(reg_wdata[0])) else $error("prescale bit wrong");
  a_mult_low_write: assert property (reg_wr && reg_addr == 7'h71 |=>
    profile_b_multiplier_low == $past(reg_wdata)) else $error("multiplier low wrong");
  a_mult_high_write: assert property (reg_wr && reg_addr == 7'h72 |=>
    profile_b_multiplier_high == $past(reg_wdata[5:0])) else $error("multiplier high wrong");
  // the verdict is formed with the limits that stood at the closing tick
  a_fail_verdict: assert property (window_done |->
    freq_fail == (last_count < $past(lo_lim) || last_count > $past(hi_lim)))
    else $error("fail verdict wrong");
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  // main scenarios
  c_window_pass: cover property (window_done && !freq_fail);
  c_window_fail: cover property (window_done && freq_fail);
  c_prescaled: cover property (window_done && profile_a_prescale_enable);
endmodule // cfm_top_properties
bind cfm_top cfm_top_properties u_chk (.clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
  .reg_rvalid, .freq_fail, .window_done, .last_count, .profile_a_low_limit_lsbyte,
  .profile_a_low_limit_msbyte, .profile_a_high_limit_lsbyte, .profile_a_high_limit_msbyte,
  .profile_a_window_cycle_count, .profile_a_prescale_enable, .profile_b_multiplier_low,
  .profile_b_multiplier_high);
`default_nettype wire

// >>> bench/cfm_top_tb.sv
// self-checking bench for the custom profile register bank and monitor
// assumes cfm_top with a decoded byte port and a clk-synchronous reference
`timescale 1ns/10ps
`default_nettype none
module cfm_top_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [6:0]  reg_addr = 7'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        mon_en = 1'b0;
  logic        ref_in = 1'b0;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic        freq_fail;
  logic        window_done;
  logic [15:0] last_count;
  logic [7:0]  q;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          ph = 0;
  // address, written byte, expected read back
  logic [22:0] rows [0:9] = '{{7'h6b, 8'h5a, 8'h5a}, {7'h6c, 8'ha5, 8'ha5},
    {7'h6d, 8'h3c, 8'h3c}, {7'h6e, 8'hc3, 8'hc3}, {7'h6f, 8'h81, 8'h81},
    {7'h70, 8'hff, 8'h01}, {7'h71, 8'he7, 8'he7}, {7'h72, 8'hff, 8'h3f},
    {7'h10, 8'haa, 8'h00}, {7'h73, 8'h55, 8'h00}};
  cfm_top DUT (.clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
    .mon_en, .ref_in, .freq_fail, .window_done, .last_count,
    .profile_a_low_limit_lsbyte(), .profile_a_low_limit_msbyte(),
    .profile_a_high_limit_lsbyte(), .profile_a_high_limit_msbyte(),
    .profile_a_window_cycle_count(), .profile_a_prescale_enable(),
    .profile_b_multiplier_low(), .profile_b_multiplier_high());
  // 50 MHz clock
  always #10 clk = ~clk;
  // reference with a period of ten clocks
  always @(posedge clk) begin
    #1;
    ph = (ph + 1) % 10;
    ref_in = (ph < 5);
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk) #1;
    reg_wr = 1'b0;
  endtask
  // read waits a bounded time for the answer pulse
  task automatic rd(input logic [6:0] a);
    int i;
    @(posedge clk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk) #1;
    reg_rd = 1'b0;
    for (i = 0; i < 3 && reg_rvalid !== 1'b1; i++) @(posedge clk) #1;
    if (reg_rvalid !== 1'b1) begin
      n_fail++;
      report_and_stop;
    end
    q = reg_rdata;
  endtask
  // wait for one window end and check its count and verdict
  task automatic win(input logic [15:0] cnt, input logic fl);
    int i;
    for (i = 0; i < 600 && window_done !== 1'b1; i++) @(posedge clk) #1;
    if (window_done !== 1'b1) begin
      n_fail++;
      report_and_stop;
    end
    chk("last_count", last_count, cnt);
    chk("freq_fail", {15'h0000, freq_fail}, {15'h0000, fl});
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    // reset value, write, read back for every row
    for (int r = 0; r < 10; r++) begin
      rd(rows[r][22:16]);
      chk("reset value", {8'h00, q}, 16'h0000);
      wr(rows[r][22:16], rows[r][15:8]);
      rd(rows[r][22:16]);
      chk("read back", {8'h00, q}, {8'h00, rows[r][7:0]});
    end
    $display("register table test done");
    // limits 20..20, two reference cycles per window
    wr(7'h6b, 8'h14);
    wr(7'h6c, 8'h00);
    wr(7'h6d, 8'h14);
    wr(7'h6e, 8'h00);
    wr(7'h6f, 8'h01);
    wr(7'h70, 8'h00);
    mon_en = 1'b1;
    win(16'd20, 1'b0);
    $display("plain window test done");
    // prescaled windows are four times longer and exceed the limit
    mon_en = 1'b0;
    wr(7'h70, 8'h01); // a 5 MHz reference, prescaler optional
    mon_en = 1'b1;
    win(16'd80, 1'b1);
    // dropping the enable clears a standing failure
    mon_en = 1'b0;
    @(posedge clk) #1;
    chk("fail while off", {15'h0000, freq_fail}, 16'h0000);
    mon_en = 1'b1;
    win(16'd80, 1'b1);
    $display("prescaled window test done");
    // reset in mid-run clears the bank
    rst = 1'b1;
    @(posedge clk) #1;
    rst = 1'b0;
    mon_en = 1'b0;
    rd(7'h6d);
    chk("after reset", {8'h00, q}, 16'h0000);
    chk("fail after reset", {15'h0000, freq_fail}, 16'h0000);
    chk("count after reset", last_count, 16'h0000);
    $display("mid-run reset test done");
    report_and_stop;
  end
endmodule // cfm_top_tb
`default_nettype wire

// >>> pkg/cfm_consts.vh
// constants for the custom profile frequency-count monitor register bank
// assumes inclusion by the design file only; definitions, no logic
//
// What this block does
// - profile A low count limit is 16 bits, low byte 0x6b, high byte 0x6c
// - profile A high count limit is 16 bits, low byte 0x6d, high byte 0x6e
// - each profile A window spans the 0x6f value plus one reference cycles
// - bit 0 of 0x70 divides the profile A reference by 4 before counting
// - profile B frequency is a 14-bit multiple of 8 kHz, bits 7:0 at 0x71
// - profile B multiplier bits 13:8 come from bits 5:0 of 0x72
`ifndef CFM_CONSTS_VH
`define CFM_CONSTS_VH

// register addresses on the configuration port
`define CFM_ADDR_LOW_LO    7'h6b
`define CFM_ADDR_LOW_HI    7'h6c
`define CFM_ADDR_HIGH_LO   7'h6d
`define CFM_ADDR_HIGH_HI   7'h6e
`define CFM_ADDR_CYCLES    7'h6f
`define CFM_ADDR_PRESCALE  7'h70
`define CFM_ADDR_MULT_LO   7'h71
`define CFM_ADDR_MULT_HI   7'h72

// reset values
`define CFM_RST_BYTE       8'h00
`define CFM_RST_BIT        1'b0
`define CFM_RST_MULT_HI    6'h00

// field positions and widths
`define CFM_PRESCALE_BIT   0
`define CFM_MULT_HI_MSB    5
`define CFM_RSVD_PRE_ZERO  7'h00
`define CFM_RSVD_MULT_ZERO 2'h0

// divide-by-4 prescaler: terminal value of a 2-bit edge counter
`define CFM_PRESCALE_LAST  2'h3
`define CFM_PRESCALE_ZERO  2'h0

// window clock counter stall limit and step values
`define CFM_COUNT_MAX      16'hffff
`define CFM_COUNT_ZERO     16'h0000
`define CFM_COUNT_ONE      16'h0001
`define CFM_TICKS_ZERO     8'h00
`define CFM_TICKS_ONE      8'h01

`endif

// >>> verilog/cfm_top.v
// custom profile register bank and profile A frequency-count monitor
// assumes the serial port front end delivers decoded byte accesses,
// and the reference input is already synchronous to clk
`timescale 1ns/10ps
`default_nettype none
`include "cfm_consts.vh"

module cfm_top (
  input  wire        clk,
  input  wire        rst,
  // decoded configuration port access
  input  wire [6:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output reg         reg_rvalid,
  // reference assigned to custom profile A
  input  wire        mon_en,
  input  wire        ref_in,
  // monitor results
  output reg         freq_fail,
  output reg         window_done,
  output reg  [15:0] last_count,
  // configuration outputs
  output reg  [7:0]  profile_a_low_limit_lsbyte,
  output reg  [7:0]  profile_a_low_limit_msbyte,
  output reg  [7:0]  profile_a_high_limit_lsbyte,
  output reg  [7:0]  profile_a_high_limit_msbyte,
  output reg  [7:0]  profile_a_window_cycle_count,
  output reg         profile_a_prescale_enable,
  output reg  [7:0]  profile_b_multiplier_low,
  output reg  [5:0]  profile_b_multiplier_high
);

  // one-hot monitor states
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_MEAS = 2'b10;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg         ref_prev_r;
  reg  [1:0]  pre_cnt_r;
  reg  [7:0]  tick_cnt_r;
  reg  [7:0]  tick_cnt_nxt;
  reg  [15:0] clk_cnt_r;
  reg  [15:0] clk_cnt_nxt;
  reg         end_win;
  reg         lost_ref;
  reg  [7:0]  rd_mux;

  wire        ref_rise;
  wire        ref_tick;
  wire [15:0] low_limit;
  wire [15:0] high_limit;
  wire        win_fail;

  // limits assembled from byte pairs; the multiplier halves leave as two ports
  assign low_limit  = {profile_a_low_limit_msbyte,
                       profile_a_low_limit_lsbyte};
  assign high_limit = {profile_a_high_limit_msbyte,
                       profile_a_high_limit_lsbyte};

  // register writes; reserved bits are not stored
  always @(posedge clk) begin
    if (rst) begin
      profile_a_low_limit_lsbyte   <= `CFM_RST_BYTE;
      profile_a_low_limit_msbyte   <= `CFM_RST_BYTE;
      profile_a_high_limit_lsbyte  <= `CFM_RST_BYTE;
      profile_a_high_limit_msbyte  <= `CFM_RST_BYTE;
      profile_a_window_cycle_count <= `CFM_RST_BYTE;
      profile_a_prescale_enable    <= `CFM_RST_BIT;
      profile_b_multiplier_low     <= `CFM_RST_BYTE;
      profile_b_multiplier_high    <= `CFM_RST_MULT_HI;
    end else if (reg_wr) begin
      case (reg_addr)
        `CFM_ADDR_LOW_LO: begin
          profile_a_low_limit_lsbyte <= reg_wdata;
        end
        `CFM_ADDR_LOW_HI: begin
          profile_a_low_limit_msbyte <= reg_wdata;
        end
        `CFM_ADDR_HIGH_LO: begin
          profile_a_high_limit_lsbyte <= reg_wdata;
        end
        `CFM_ADDR_HIGH_HI: begin
          profile_a_high_limit_msbyte <= reg_wdata;
        end
        `CFM_ADDR_CYCLES: begin
          profile_a_window_cycle_count <= reg_wdata;
        end
        `CFM_ADDR_PRESCALE: begin
          profile_a_prescale_enable <= reg_wdata[`CFM_PRESCALE_BIT];
        end
        `CFM_ADDR_MULT_LO: begin
          profile_b_multiplier_low <= reg_wdata;
        end
        `CFM_ADDR_MULT_HI: begin
          profile_b_multiplier_high <= reg_wdata[`CFM_MULT_HI_MSB:0];
        end
        default: begin
          profile_a_prescale_enable <= profile_a_prescale_enable;     // unmapped: ignored
        end
      endcase
    end
  end

  // read mux; reserved bits and unmapped addresses read as zero
  always @* begin
    case (reg_addr)
      `CFM_ADDR_LOW_LO:   rd_mux = profile_a_low_limit_lsbyte;
      `CFM_ADDR_LOW_HI:   rd_mux = profile_a_low_limit_msbyte;
      `CFM_ADDR_HIGH_LO:  rd_mux = profile_a_high_limit_lsbyte;
      `CFM_ADDR_HIGH_HI:  rd_mux = profile_a_high_limit_msbyte;
      `CFM_ADDR_CYCLES:   rd_mux = profile_a_window_cycle_count;
      `CFM_ADDR_PRESCALE: rd_mux = {`CFM_RSVD_PRE_ZERO, profile_a_prescale_enable};
      `CFM_ADDR_MULT_LO:  rd_mux = profile_b_multiplier_low;
      `CFM_ADDR_MULT_HI:  rd_mux = {`CFM_RSVD_MULT_ZERO, profile_b_multiplier_high};
      default:            rd_mux = `CFM_RST_BYTE;
    endcase
  end

  // read data is registered, valid the cycle after the strobe
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata  <= `CFM_RST_BYTE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // reference edge detect
  always @(posedge clk) begin
    if (rst) begin
      ref_prev_r <= 1'b0;
    end else begin
      ref_prev_r <= ref_in;
    end
  end

  assign ref_rise = ref_in & ~ref_prev_r;

  // divide-by-4 prescaler passes every fourth rising edge when enabled
  always @(posedge clk) begin
    if (rst || !mon_en || !profile_a_prescale_enable) begin
      pre_cnt_r <= `CFM_PRESCALE_ZERO;
    end else if (ref_rise) begin
      pre_cnt_r <= pre_cnt_r + 2'h1;
    end
  end

  assign ref_tick = ref_rise &
                    (~profile_a_prescale_enable |
                     (pre_cnt_r == `CFM_PRESCALE_LAST));

  // window end: cycle count plus one prescaled reference periods seen
  always @* begin
    end_win  = 1'b0;
    lost_ref = 1'b0;
    if (state_r == ST_MEAS) begin
      if (ref_tick && (tick_cnt_r == profile_a_window_cycle_count)) begin
        end_win = 1'b1;
      end else if (clk_cnt_r == `CFM_COUNT_MAX) begin
        end_win  = 1'b1;                                              // reference stalled
        lost_ref = 1'b1;
      end
    end
  end

  // out-of-range count, or a stalled reference, fails the window
  assign win_fail = lost_ref |
                    (clk_cnt_r < low_limit) |
                    (clk_cnt_r > high_limit);

  // monitor state machine and counters
  always @* begin
    state_nxt    = state_r;
    tick_cnt_nxt = tick_cnt_r;
    clk_cnt_nxt  = clk_cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (mon_en && ref_tick) begin
          state_nxt    = ST_MEAS;                                     // window opens on a tick
          tick_cnt_nxt = `CFM_TICKS_ZERO;
          clk_cnt_nxt  = `CFM_COUNT_ONE;
        end
      end
      ST_MEAS: begin
        if (!mon_en) begin
          state_nxt = ST_IDLE;
        end else if (end_win) begin
          // closing tick opens the next window back to back
          state_nxt    = lost_ref ? ST_IDLE : ST_MEAS;
          tick_cnt_nxt = `CFM_TICKS_ZERO;
          clk_cnt_nxt  = `CFM_COUNT_ONE;
        end else begin
          clk_cnt_nxt = clk_cnt_r + `CFM_COUNT_ONE;
          if (ref_tick) begin
            tick_cnt_nxt = tick_cnt_r + `CFM_TICKS_ONE;
          end
        end
      end
      default: begin
        state_nxt    = ST_IDLE;
        tick_cnt_nxt = `CFM_TICKS_ZERO;
        clk_cnt_nxt  = `CFM_COUNT_ZERO;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_r    <= ST_IDLE;
      tick_cnt_r <= `CFM_TICKS_ZERO;
      clk_cnt_r  <= `CFM_COUNT_ZERO;
    end else begin
      state_r    <= state_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      clk_cnt_r  <= clk_cnt_nxt;
    end
  end

  // results latched at each window end; flag cleared when disabled
  always @(posedge clk) begin
    if (rst) begin
      freq_fail   <= 1'b0;
      window_done <= 1'b0;
      last_count  <= `CFM_COUNT_ZERO;
    end else begin
      window_done <= end_win & mon_en;
      if (!mon_en) begin
        freq_fail <= 1'b0;
      end else if (end_win) begin
        freq_fail  <= win_fail;
        last_count <= clk_cnt_r;
      end
    end
  end

endmodule // cfm_top

`default_nettype wire
